// ### rtl/giq_pkg.sv
// constants and carrier types for the gpio input qualifier
// assumes one system clock; pins arrive asynchronous to it
//
// Overview of operation
// R1: period zero samples every clock
// R2: period n samples every 2n clocks
// R3: period field eight bits, full range
// R4: one period setting per eight pins
// R5: three or six samples, chosen per pin
// R6: three-sample window is two periods
// R7: six-sample window is five periods
// R8: excursions shorter than window are ignored
// R9: driver holds level window plus period
// R10: same widths apply to int2/conv start
// R11: wake request lasts 2, or 5+window
// R12: active resume within 20 plus window
// R13: sleeping flash resume within 1050 plus window
// R14: latency ends at next instruction start
// R15: leave idle on int, watchdog, nmi, reset
// R16: each pin holds level until agreement
package giq_pkg;
	localparam int unsigned SYS_CLK_MHZ      = 125;
	localparam int unsigned PERIOD_W         = 8;
	localparam int unsigned GROUP_PINS       = 8;
	localparam int unsigned SAMPLES_3        = 3;
	localparam int unsigned SAMPLES_6        = 6;
	localparam int unsigned RESUME_ACTIVE_CYC = 20;
	localparam int unsigned RESUME_SLEEP_CYC = 1050;
	localparam int unsigned RESUME_W         = 12;
	localparam logic [PERIOD_W-1:0] PERIOD_RST = 8'h00;

	typedef enum logic {
		GIQ_RUN,
		GIQ_IDLE
	} giq_pwr_t;

	typedef struct packed {
		logic enabled_int;
		logic watchdog_interrupt;
		logic ext_nonmaskable_interrupt;
		logic reset_pin;
	} giq_wake_t;
endpackage

// ### rtl/giq_pin_filter.sv
// one pin: sample history and qualified level
// assumes pin already synchronised and a shared sample strobe
`timescale 1ns/1ns
module giq_pin_filter
	import giq_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// sampling
	input  wire logic sample_en,
	input  wire logic six_mode,
	input  wire logic pin_sync,
	// result
	output logic      qual_out
);
	logic [5:0] hist;

	// shift history on each sample
	always_ff @(posedge clk) begin
		if (srst)
			hist <= 6'h00;
		else if (sample_en)
			hist <= {hist[4:0], pin_sync};
	end

	// accept only when all selected samples agree
	always_ff @(posedge clk) begin
		if (srst)
			qual_out <= 1'b0;
		else if (six_mode) begin // R5
			if (&hist) // R7 R8 R16
				qual_out <= 1'b1;
			else if (~|hist)
				qual_out <= 1'b0;
		end else begin
			if (&hist[2:0]) // R6 R8 R16
				qual_out <= 1'b1;
			else if (~|hist[2:0])
				qual_out <= 1'b0;
		end
	end

	chk_glitch_hold: assert property (@(posedge clk) disable iff (srst) // R8
		(!six_mode && !(&hist[2:0]) && !(~|hist[2:0])) |=> $stable(qual_out))
		else $error("qualified level moved without agreement");
endmodule

// ### rtl/giq_qualifier.sv
// gpio input qualifier with idle wake-up sequencing
// assumes pins asynchronous to clk; controls from same-clock logic
`timescale 1ns/1ns
module giq_qualifier
	import giq_pkg::*;
#(
	parameter int unsigned NPINS = 16
)(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         srst,
	// pins
	input  wire logic [NPINS-1:0]             gpio_pin,
	input  wire logic                         ext_int2_conv_start,
	// configuration
	input  wire logic [NPINS/GROUP_PINS-1:0][PERIOD_W-1:0] qual_period_field,
	input  wire logic [NPINS-1:0]             qual_sample_select,
	input  wire logic [NPINS-1:0]             qual_enable,
	// low power
	input  wire logic                         idle_enter,
	input  wire logic                         flash_sleep,
	input  wire giq_pkg::giq_wake_t           wake_src,
	// results
	output logic [NPINS-1:0]                  gpio_qual,
	output logic                              int2_qual,
	output logic                              idle_active,
	output logic                              resume_pulse
);
	import giq_pkg::*;

	localparam int unsigned NGRP = NPINS / GROUP_PINS;

	logic [NPINS:0] meta;
	logic [NPINS:0] sync;
	logic [NGRP-1:0][PERIOD_W:0] cnt;
	logic [NGRP-1:0] strobe;
	logic [NPINS:0] filt;
	giq_pwr_t pwr;
	logic [RESUME_W-1:0] resume_cnt;
	logic [NGRP-1:0][PERIOD_W:0] div_end;
	logic                wake_hit;
	logic                wake_armed;
	logic                wake_slept;
	logic [RESUME_W-1:0] wake_age;

	// sample period in clocks, minus one
	function automatic logic [PERIOD_W:0] period_last(input logic [PERIOD_W-1:0] p);
		if (p == PERIOD_RST)
			return '0; // R1
		return {p, 1'b0} - 9'h001; // R2 R3
	endfunction

	// two-flop synchroniser
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= '0;
			sync <= '0;
		end else begin
			meta <= {ext_int2_conv_start, gpio_pin};
			sync <= meta;
		end
	end

	// per-group sample strobe
	always_comb begin
		for (int g = 0; g < NGRP; g++) begin
			div_end[g] = period_last(qual_period_field[g]);
			strobe[g]  = (cnt[g] >= div_end[g]);
		end
	end

	always_ff @(posedge clk) begin
		for (int g = 0; g < NGRP; g++) begin
			if (srst || strobe[g])
				cnt[g] <= '0; // R4
			else
				cnt[g] <= cnt[g] + 9'h001;
		end
	end

	// filters; int2 shares group 0 period and pin 0 select
	for (genvar i = 0; i <= NPINS; i++) begin : g_pin
		localparam int unsigned GI = (i == NPINS) ? 0 : i / GROUP_PINS;
		localparam int unsigned SI = (i == NPINS) ? 0 : i;
		giq_pin_filter u_f (
			.clk      (clk),
			.srst     (srst),
			.sample_en(strobe[GI]),
			.six_mode (qual_sample_select[SI]),
			.pin_sync (sync[i]),
			.qual_out (filt[i])
		);
	end

	// output select: synchronous or qualified
	always_ff @(posedge clk) begin
		if (srst) begin
			gpio_qual <= '0;
			int2_qual <= 1'b0;
		end else begin
			for (int i = 0; i < NPINS; i++)
				gpio_qual[i] <= qual_enable[i] ? filt[i] : sync[i];
			int2_qual <= qual_enable[0] ? filt[NPINS] : sync[NPINS]; // R10
		end
	end

	// idle state and wake sources
	always_ff @(posedge clk) begin
		if (srst)
			pwr <= GIQ_RUN;
		else begin
			unique case (pwr)
				GIQ_RUN:  if (idle_enter) pwr <= GIQ_IDLE;
				GIQ_IDLE: if (|wake_src) pwr <= GIQ_RUN; // R15
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			idle_active <= 1'b0;
		else
			idle_active <= (pwr == GIQ_IDLE) && !(|wake_src);
	end

	// resume latency to next instruction start
	always_ff @(posedge clk) begin
		if (srst) begin
			resume_cnt   <= '0;
			resume_pulse <= 1'b0;
		end else begin
			resume_pulse <= 1'b0;
			if (pwr == GIQ_IDLE && |wake_src)
				resume_cnt <= flash_sleep ? RESUME_W'(RESUME_SLEEP_CYC - 1) // R13
				                          : RESUME_W'(RESUME_ACTIVE_CYC - 1); // R12
			else if (resume_cnt != '0) begin
				resume_cnt <= resume_cnt - 12'h001;
				resume_pulse <= (resume_cnt == 12'h001); // R14
			end
		end
	end

	// wake seen while idle
	assign wake_hit = (pwr == GIQ_IDLE) && (|wake_src);

	// age of the pending wake, for the latency checks
	always_ff @(posedge clk) begin
		if (srst) begin
			wake_armed <= 1'b0;
			wake_slept <= 1'b0;
			wake_age   <= '0;
		end else if (wake_hit) begin
			wake_armed <= 1'b1;
			wake_slept <= flash_sleep;
			wake_age   <= 12'h001;
		end else if (wake_armed) begin
			wake_armed <= !resume_pulse;
			wake_age   <= wake_age + 12'h001;
		end
	end

	// strobe, resume, wake-exit, counter and path checks
	chk_zero_period: assert property (@(posedge clk) disable iff (srst) // R1
		(qual_period_field[0] == 8'h00) |-> strobe[0])
		else $error("period zero must strobe every clock");
	chk_strobe_spacing: assert property (@(posedge clk) disable iff (srst) // R2
		(strobe[NGRP-1] && qual_period_field[NGRP-1] == 8'h01 && $stable(qual_period_field[NGRP-1]))
		|=> !strobe[NGRP-1] ##1 strobe[NGRP-1])
		else $error("period one must strobe every two clocks");
	chk_active_resume: assert property (@(posedge clk) disable iff (srst) // R12
		(pwr == GIQ_IDLE && |wake_src && !flash_sleep) |-> ##20 resume_pulse)
		else $error("active resume not at twenty clocks");
	chk_sleep_resume: assert property (@(posedge clk) disable iff (srst) // R13
		(wake_armed && wake_slept && wake_age == RESUME_W'(RESUME_SLEEP_CYC)) |-> resume_pulse)
		else $error("sleep resume not at its latency");
	chk_wake_exit: assert property (@(posedge clk) disable iff (srst) // R15
		(pwr == GIQ_IDLE && |wake_src) |=> pwr == GIQ_RUN)
		else $error("wake source did not leave idle");
	chk_sync_path: assert property (@(posedge clk) disable iff (srst) // R9
		!qual_enable[0] |=> gpio_qual[0] == $past(sync[0]))
		else $error("synchronous path mismatch");
	chk_int2_path: assert property (@(posedge clk) disable iff (srst) // R10
		!qual_enable[0] |=> int2_qual == $past(sync[NPINS]))
		else $error("int2 synchronous path mismatch");
	chk_group_period: assert property (@(posedge clk) disable iff (srst) // R4
		cnt[0] <= 9'h1fe)
		else $error("group counter overran");

	// idle, resume and qualified path checks
	chk_resume_exact: assert property (@(posedge clk) disable iff (srst) // R14
		(wake_armed && resume_pulse) |->
		wake_age == (wake_slept ? RESUME_W'(RESUME_SLEEP_CYC) : RESUME_W'(RESUME_ACTIVE_CYC)))
		else $error("resume pulse off its latency");
	chk_sleep_bound: assert property (@(posedge clk) disable iff (srst) // R13
		wake_armed |-> wake_age <= RESUME_W'(RESUME_SLEEP_CYC))
		else $error("sleep resume overran");
	chk_active_bound: assert property (@(posedge clk) disable iff (srst) // R12
		(wake_armed && !wake_slept) |-> wake_age <= RESUME_W'(RESUME_ACTIVE_CYC))
		else $error("active resume overran");
	chk_idle_flag: assert property (@(posedge clk) disable iff (srst) // R15
		idle_active |-> ($past(pwr) == GIQ_IDLE) && !$past(|wake_src))
		else $error("idle flag without idle state");
	chk_run_hold: assert property (@(posedge clk) disable iff (srst) // R15
		(pwr == GIQ_RUN && !idle_enter) |=> pwr == GIQ_RUN)
		else $error("left run without idle request");
	chk_idle_entry: assert property (@(posedge clk) disable iff (srst) // R15
		(pwr == GIQ_RUN && idle_enter) |=> pwr == GIQ_IDLE)
		else $error("idle request not taken");
	chk_resume_single: assert property (@(posedge clk) disable iff (srst) // R14
		resume_pulse |=> !resume_pulse)
		else $error("resume pulse longer than one cycle");
	chk_qual_follow: assert property (@(posedge clk) disable iff (srst) // R16
		qual_enable[0] |=> gpio_qual[0] == $past(filt[0]))
		else $error("qualified path mismatch");
	chk_int2_qual: assert property (@(posedge clk) disable iff (srst) // R10
		qual_enable[0] |=> int2_qual == $past(filt[NPINS]))
		else $error("int2 qualified path mismatch");

	cov_wake: cover property (@(posedge clk) resume_pulse);
	cov_idle: cover property (@(posedge clk) pwr == GIQ_IDLE);
	cov_qual_rise: cover property (@(posedge clk) $rose(gpio_qual[0]) && qual_enable[0]);
	cov_sleep_resume: cover property (@(posedge clk) resume_pulse && wake_slept);
	cov_int2_sync: cover property (@(posedge clk) $rose(int2_qual) && !qual_enable[0]);
endmodule

// ### test/giq_pin_drv.sv
// external driver model for the pins
// assumes the bench holds each level long enough
`timescale 1ns/1ns
module giq_pin_drv (
	// clock
	input  wire logic        clk,
	// wanted levels
	input  wire logic [16:0] want,
	// pins, bit 16 is int2
	output logic      [16:0] pin
);
	// levels reach pins on clock
	always_ff @(posedge clk) begin
		pin <= want;
	end
endmodule

// ### test/gpio_input_qualifier_tb_top.sv
// bench for the gpio input qualifier
// assumes giq_pkg and the driver model
`timescale 1ns/1ns
module gpio_input_qualifier_tb_top;
	import giq_pkg::*;
	logic            clk = 0;
	logic            srst = 1;
	logic [16:0]     want = '0;
	logic [16:0]     pin;
	logic [1:0][7:0] prd = '0;
	logic [15:0]     sel = '0;
	logic [15:0]     qen = '0;
	logic            idle_enter = 0;
	logic            flash_sleep = 0;
	giq_wake_t       wake = '0;
	logic [15:0]     gq;
	logic            i2q;
	logic            idl;
	logic            rsm;
	wire  [16:0]     q = {i2q, gq};
	int              err_total = 0;
	int              n_compared = 0;
	int              cyc = 0;
	always #4 clk = ~clk;
	giq_pin_drv u_drv (.clk(clk), .want(want), .pin(pin));
	giq_qualifier u_dut (.clk(clk), .srst(srst), .gpio_pin(pin[15:0]), .ext_int2_conv_start(pin[16]),
		.qual_period_field(prd), .qual_sample_select(sel), .qual_enable(qen),
		.idle_enter(idle_enter), .flash_sleep(flash_sleep), .wake_src(wake),
		.gpio_qual(gq), .int2_qual(i2q), .idle_active(idl), .resume_pulse(rsm));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// high pulse of len cycles; seen if output ever rose
	task automatic pulse(input int b, input int len, output logic seen);
		seen = 0;
		@(posedge clk) want[b] <= 1;
		repeat (len) @(posedge clk) seen |= q[b];
		want[b] <= 0;
		repeat (40) @(posedge clk) seen |= q[b];
	endtask
	task automatic t_sync;
		logic s;
		pulse(0, 2, s); chk(s, 1);
		pulse(16, 2, s); chk(s, 1);
	endtask
	task automatic t_three;
		logic s;
		@(posedge clk) qen <= '1;
		pulse(3, 2, s); chk(s, 0);
		pulse(3, 4, s); chk(s, 1);
		pulse(16, 2, s); chk(s, 0);
	endtask
	task automatic t_six;
		logic s;
		@(posedge clk) sel[4] <= 1;
		pulse(4, 5, s); chk(s, 0);
		pulse(4, 7, s); chk(s, 1);
	endtask
	task automatic t_prd;
		logic s;
		@(posedge clk) prd[1] <= 8'h01;
		sel[9] <= 1;
		pulse(9, 9, s); chk(s, 0);
		pulse(9, 13, s); chk(s, 1);
		pulse(0, 4, s); chk(s, 1);
	endtask
	task automatic t_wake(input giq_wake_t w, input logic fs, input int lat);
		int n;
		@(posedge clk) idle_enter <= 1;
		flash_sleep <= fs;
		@(posedge clk) idle_enter <= 0;
		@(posedge clk);
		@(posedge clk) wake <= w;
		chk(idl, 1);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (rsm !== 1 && n < 1100);
		@(posedge clk) wake <= '0;
		chk(n, lat);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		srst <= 0;
		t_sync; $display("sync done");
		t_three; $display("three done");
		t_six; $display("six done");
		t_prd; $display("period done");
		for (int i = 0; i < 4; i++)
			t_wake(giq_wake_t'(4'h1 << i), 0, RESUME_ACTIVE_CYC);
		t_wake(giq_wake_t'(4'h8), 1, RESUME_SLEEP_CYC);
		$display("wake done");
		end_of_test;
	end
endmodule
